// >>> include/dpwa_pkg.sv
// Overview of operation
// (R1) the device writes only while select and write strobe are both low
// (R2) address changes only while select or write strobe is high
// (R3) select falling with or after strobe keeps device outputs high-impedance
// (R4) output enable low stretches strobe to turnoff plus data setup
// (R5) write completion is timed from the first of select or strobe rising
// (R6) the earlier port wins when arrivals differ by the priority setup time; the device model flags this side on any clash, whoever came first
// (R7) master flags contention within access time of an address match
// (R8) master flags contention within delay after the later select falls
// (R9) slave contention input must be asserted by the start of the strobe
// (R10) after contention releases, strobe stays low for the write hold time
// (R11) written data reaches the other port within the port-to-port delays
// (R12) valid data after release follows a derived, non-negative delay
// (R13) release-to-valid-data timing applies to the master only
// (R14) left and right ports behave the same way
// (R15) a port with its contention flag low has its write blocked
// (R16) a violated priority setup still flags exactly one port
// (R17) contention only with both ports selected and addresses equal
package dpwa_pkg;
	localparam int CLK_NS = 50;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 8;
	localparam int TMR_W = 4;
	localparam int SYNC_CYC = 2;

	localparam int T_WP_NS = 55;
	localparam int T_WZ_NS = 40;
	localparam int T_DW_NS = 40;
	localparam int T_WR_HOLD_NS = 20;
	localparam int T_CONT_ASSERT_NS = 50;
	localparam int T_APS_NS = 5;
	localparam int T_READ_NS = 100;

	function automatic int cycMin(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		cycMin = (c < 1) ? 1 : c;
	endfunction : cycMin

	function automatic int cycMax(input int ns);
		int c;
		c = ns / CLK_NS;
		cycMax = (c < 1) ? 1 : c;
	endfunction : cycMax

	localparam int PULSE_CYC = cycMin(T_WP_NS);
	localparam int WZ_CYC = cycMin(T_WZ_NS);
	localparam int DW_CYC = cycMin(T_DW_NS);
	localparam int STROBE_OE_CYC = (PULSE_CYC - WZ_CYC > DW_CYC) ? PULSE_CYC - WZ_CYC : DW_CYC;
	localparam int WR_HOLD_CYC = cycMin(T_WR_HOLD_NS);
	localparam int APS_CYC = cycMin(T_APS_NS);
	localparam int SETTLE_CYC = (cycMax(T_CONT_ASSERT_NS) > APS_CYC) ?
		cycMax(T_CONT_ASSERT_NS) : APS_CYC;
	localparam int READ_CYC = cycMin(T_READ_NS) + SYNC_CYC;

	localparam logic PIN_IDLE_LEVEL = 1'b1;

	typedef struct packed {
		logic write;
		logic keepOeLow;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} dpwa_req_t;

	typedef struct packed {
		logic blocked;
		logic [DATA_W-1:0] data;
	} dpwa_rsp_t;

	typedef struct packed {
		logic selectN;
		logic writeStrobeN;
		logic outEnableN;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dataOut;
		logic dataOutEn;
	} dpwa_pins_t;
endpackage : dpwa_pkg

// >>> verif/dpwa_dev_model.sv
`timescale 1ns/1ps
module dpwa_dev_model (
	input wire dpwa_pkg::dpwa_pins_t pins,
	input wire logic otherSel,
	input wire logic [dpwa_pkg::ADDR_W-1:0] otherAddr,
	output logic [dpwa_pkg::DATA_W-1:0] dataIn,
	output logic contentionN
);
	import dpwa_pkg::*;
	logic [DATA_W-1:0] mem [2**ADDR_W];
	logic [DATA_W-1:0] lastData;
	logic devDrive;
	logic [DATA_W-1:0] rdWord;
	initial begin
		lastData = '0;
		foreach (mem[i]) mem[i] = '0;
	end
	// flag only with both sides selected on one address, shortest grade delay
	// the far port is taken to win every tie, so only this side is flagged
	assign #20 contentionN = !(otherSel && !pins.selectN &&
		pins.addr == otherAddr);
	// outputs stay off while a strobe is low
	assign devDrive = !pins.selectN && !pins.outEnableN && pins.writeStrobeN;
	// store during the overlap, held off while flagged, ends on first rise
	always @(pins or contentionN) begin
		if (!pins.selectN && !pins.writeStrobeN && contentionN === 1'b1 &&
			pins.dataOutEn) begin
			mem[pins.addr] = pins.dataOut;
		end
	end
	// flagged read shows a corrupt word; valid again as the flag releases
	assign rdWord = (contentionN === 1'b1) ? mem[pins.addr] : ~mem[pins.addr];
	always @(dataIn) begin
		if (pins.dataOutEn || devDrive) begin
			lastData = dataIn;
		end
	end
	// released line shows the inverse of its last level
	assign dataIn = pins.dataOutEn ? pins.dataOut : devDrive ? rdWord : ~lastData;
endmodule : dpwa_dev_model

// >>> verif/dpwa_tb_top.sv
`timescale 1ns/1ps
module dpwa_tb_top;
	import dpwa_pkg::*;
	logic clk_sys, reset, reqValid, reqReady, rspValid, contentionN, otherSel;
	dpwa_req_t req;
	dpwa_rsp_t rsp;
	dpwa_pins_t pins;
	logic [DATA_W-1:0] dataIn;
	logic [ADDR_W-1:0] otherAddr;
	int fails, tests_run;
	int expMem[int];
	dpwa_port_ctrl DUT (.clk_sys(clk_sys), .reset(reset), .reqValid(reqValid), .req(req),
		.reqReady(reqReady), .rspValid(rspValid), .rsp(rsp), .pins(pins), .dataIn(dataIn),
		.contentionN(contentionN));
	dpwa_dev_model devModel (.pins(pins), .otherSel(otherSel), .otherAddr(otherAddr),
		.dataIn(dataIn), .contentionN(contentionN));
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : complete_run
	task automatic check_data(string what, logic [DATA_W-1:0] expV, logic [DATA_W-1:0] got);
		tests_run++;
		if (got !== expV) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, expV, got);
		end
	endtask : check_data
	task automatic check_flag(string what, logic expV, logic got);
		tests_run++;
		if (got !== expV) begin
			fails++;
			$display("ERROR %s expected %b seen %b", what, expV, got);
		end
	endtask : check_flag
	task automatic check_count(string what, int expV, int got);
		tests_run++;
		if (got != expV) begin
			fails++;
			$display("ERROR %s expected %0d seen %0d", what, expV, got);
		end
	endtask : check_count
	task automatic do_op(logic wr, logic oe, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d,
		int busyCyc, logic [ADDR_W-1:0] oa);
		int n;
		logic hit;
		hit = busyCyc > 0 && oa == a;
		@(negedge clk_sys);
		otherSel = busyCyc > 0;
		otherAddr = oa;
		req = '{wr, oe, a, d};
		reqValid = 1'b1;
		check_flag("reqReady", 1'b1, reqReady);
		@(posedge clk_sys);
		n = 0;
		@(negedge clk_sys);
		reqValid = 1'b0;
		n = 1;
		while (rspValid !== 1'b1 && n < 100) begin
			@(negedge clk_sys);
			n++;
			if (n == busyCyc) otherSel = 1'b0;
		end
		otherSel = 1'b0;
		if (rspValid !== 1'b1) begin
			fails++;
			complete_run();
		end
		if (!hit) check_count("latency", 5, n);
		check_flag("blocked", hit, rsp.blocked);
		if (wr) begin
			expMem[a] = d;
			check_data("wdata", d, rsp.data);
		end else if (!hit) begin
			check_data("rdata", expMem.exists(a) ? expMem[a] : 0, rsp.data);
		end
	endtask : do_op
	initial begin
		logic [ADDR_W-1:0] a;
		logic [DATA_W-1:0] d;
		reset = 1'b1;
		reqValid = 1'b0;
		req = '0;
		otherSel = 1'b0;
		otherAddr = '0;
		fails = 0;
		tests_run = 0;
		void'($urandom(71044));
		repeat (20) @(posedge clk_sys);
		@(negedge clk_sys);
		reset = 1'b0;
		for (int i = 0; i < 16; i++) begin
			a = ADDR_W'($urandom);
			d = DATA_W'($urandom);
			do_op(1'b1, 1'($urandom), a, d, 0, '0);
			do_op(1'b0, 1'b0, a, '0, 0, '0);
		end
		$display("test random write and read done");
		do_op(1'b1, 1'b0, 10'h3ff, 8'ha5, 8, 10'h3ff);
		do_op(1'b0, 1'b0, 10'h3ff, 8'h00, 0, 10'h000);
		do_op(1'b1, 1'b1, 10'h000, 8'h5a, 8, 10'h001);
		do_op(1'b1, 1'b1, 10'h000, 8'hc3, 6, 10'h000);
		do_op(1'b0, 1'b0, 10'h000, 8'h00, 0, 10'h000);
		do_op(1'b0, 1'b0, 10'h000, 8'h00, 8, 10'h000);
		$display("test contention done");
		complete_run();
	end
endmodule : dpwa_tb_top

// >>> verilog/dpwa_cycle_timer.sv
`timescale 1ns/1ps
module dpwa_cycle_timer (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic load,
	input wire logic [dpwa_pkg::TMR_W-1:0] loadVal,
	output logic [dpwa_pkg::TMR_W-1:0] remain,
	output logic expired
);
	import dpwa_pkg::*;

	logic [TMR_W-1:0] remain_reg;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			remain_reg <= '0;
		end else if (load) begin
			remain_reg <= loadVal;
		end else if (remain_reg != '0) begin
			remain_reg <= remain_reg - 1'b1;
		end
	end

	assign remain = remain_reg;
	assign expired = (remain_reg == '0);
endmodule : dpwa_cycle_timer

// >>> verilog/dpwa_port_ctrl.sv
`timescale 1ns/1ps
module dpwa_port_ctrl (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic reqValid,
	input wire dpwa_pkg::dpwa_req_t req,
	output logic reqReady,
	output logic rspValid,
	output dpwa_pkg::dpwa_rsp_t rsp,
	output dpwa_pkg::dpwa_pins_t pins,
	input wire logic [dpwa_pkg::DATA_W-1:0] dataIn,
	input wire logic contentionN
);
	import dpwa_pkg::*;

	typedef enum logic [3:0] {
		IDLE, SELECT, TURNOFF, STROBE, WAITBUSY, WHOLD, ENDW, READ
	} dpwa_state_t;

	dpwa_state_t state_reg, stateNext;
	dpwa_req_t cur_reg;
	dpwa_pins_t pins_reg, pinsNext;
	dpwa_rsp_t rsp_reg;
	logic rspValid_reg;
	logic blocked_reg;
	logic busyMeta_reg, busySync_reg;
	logic [DATA_W-1:0] dataMeta_reg, dataSync_reg;
	logic tmrLoad, tmrExpired;
	logic [TMR_W-1:0] tmrLoadVal, tmrRemain;

	dpwa_cycle_timer u_timer (
		.clk_sys(clk_sys),
		.reset(reset),
		.load(tmrLoad),
		.loadVal(tmrLoadVal),
		.remain(tmrRemain),
		.expired(tmrExpired)
	);

	function automatic logic [TMR_W-1:0] cnt(input int cycles);
		cnt = TMR_W'(cycles - 1);
	endfunction : cnt

	// contention flag and read data come from the device pins
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			busyMeta_reg <= PIN_IDLE_LEVEL;
			busySync_reg <= PIN_IDLE_LEVEL;
			dataMeta_reg <= '0;
			dataSync_reg <= '0;
		end else begin
			busyMeta_reg <= contentionN;
			busySync_reg <= busyMeta_reg;
			dataMeta_reg <= dataIn;
			dataSync_reg <= dataMeta_reg;
		end
	end

	always_comb begin
		stateNext = state_reg;
		tmrLoad = 1'b0;
		tmrLoadVal = '0;
		case (state_reg)
			IDLE: begin
				if (reqValid) begin
					tmrLoad = 1'b1;
					// select first, then wait out arbitration before strobing
					stateNext = req.write ? SELECT : READ; // see (R6)
					tmrLoadVal = req.write ? cnt(SETTLE_CYC) : cnt(READ_CYC); // see (R8) (R9)
				end
			end
			SELECT: begin
				if (tmrExpired) begin
					tmrLoad = 1'b1;
					// strobe falls after select, so with output enable low the device drives until the strobe falls
					if (cur_reg.keepOeLow) begin // see (R3)
						stateNext = TURNOFF;
						tmrLoadVal = cnt(WZ_CYC); // see (R4)
					end else begin
						stateNext = STROBE;
						tmrLoadVal = cnt(PULSE_CYC); // see (R4)
					end
				end
			end
			TURNOFF: begin
				if (tmrExpired) begin
					stateNext = STROBE;
					tmrLoad = 1'b1;
					tmrLoadVal = cnt(STROBE_OE_CYC); // see (R4)
				end
			end
			STROBE: begin
				if (!busySync_reg) begin
					stateNext = WAITBUSY; // see (R15)
				end else if (tmrExpired) begin
					stateNext = ENDW;
				end
			end
			WAITBUSY: begin
				if (busySync_reg) begin
					stateNext = WHOLD;
					tmrLoad = 1'b1;
					tmrLoadVal = cnt(WR_HOLD_CYC); // see (R10)
				end
			end
			WHOLD: begin
				if (!busySync_reg) begin
					stateNext = WAITBUSY;
				end else if (tmrExpired) begin
					stateNext = ENDW;
				end
			end
			ENDW: begin
				stateNext = IDLE;
			end
			READ: begin
				if (tmrExpired) begin
					stateNext = IDLE;
				end
			end
			default: begin
				stateNext = IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_reg <= IDLE;
		end else begin
			state_reg <= stateNext;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			cur_reg <= '0;
		end else if (state_reg == IDLE && reqValid) begin
			cur_reg <= req; // see (R2)
		end
	end

	always_comb begin
		pinsNext = pins_reg;
		pinsNext.selectN = (stateNext == IDLE);
		// strobe rises one cycle before select, ending the write on it
		pinsNext.writeStrobeN = !(stateNext inside {TURNOFF, STROBE, WAITBUSY, WHOLD}); // see (R5)
		pinsNext.outEnableN = !(stateNext == READ ||
			(cur_reg.keepOeLow && stateNext inside {SELECT, TURNOFF, STROBE, WAITBUSY, WHOLD}));
		pinsNext.dataOutEn = stateNext inside {STROBE, WAITBUSY, WHOLD}; // see (R1)
		if (state_reg == IDLE && reqValid) begin
			pinsNext.addr = req.addr;
			pinsNext.dataOut = req.data;
			pinsNext.outEnableN = !(!req.write || req.keepOeLow);
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			pins_reg <= '{selectN: 1'b1, writeStrobeN: 1'b1, outEnableN: 1'b1,
				addr: '0, dataOut: '0, dataOutEn: 1'b0};
		end else begin
			pins_reg <= pinsNext;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			blocked_reg <= 1'b0;
		end else if (state_reg == IDLE) begin
			blocked_reg <= 1'b0;
		end else if (!busySync_reg) begin
			blocked_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rspValid_reg <= 1'b0;
			rsp_reg <= '0;
		end else begin
			rspValid_reg <= 1'b0;
			if (state_reg == ENDW) begin
				rspValid_reg <= 1'b1;
				rsp_reg <= '{blocked: blocked_reg, data: cur_reg.data};
			end else if (state_reg == READ && tmrExpired) begin
				rspValid_reg <= 1'b1;
				rsp_reg <= '{blocked: blocked_reg || !busySync_reg, data: dataSync_reg};
			end
		end
	end

	assign reqReady = (state_reg == IDLE);
	assign rspValid = rspValid_reg;
	assign rsp = rsp_reg;
	assign pins = pins_reg;

	// helper: cycles the strobe has been low, and since contention released
	logic [TMR_W-1:0] lowCnt_reg, relCnt_reg;
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			lowCnt_reg <= '0;
			relCnt_reg <= '0;
		end else begin
			// saturate so a long contention stall cannot wrap the count
			if (pins_reg.writeStrobeN) begin
				lowCnt_reg <= '0;
			end else if (lowCnt_reg != '1) begin
				lowCnt_reg <= lowCnt_reg + 1'b1;
			end
			if (!busySync_reg || pins_reg.writeStrobeN) begin
				relCnt_reg <= '0;
			end else if (relCnt_reg != '1) begin
				relCnt_reg <= relCnt_reg + 1'b1;
			end
		end
	end

	addr_stable_a: assert property (@(posedge clk_sys) disable iff (reset) // see (R2)
		!(pins_reg.selectN || pins_reg.writeStrobeN) |=> $stable(pins_reg.addr))
		else $error("address moved during write overlap");

	strobe_width_a: assert property (@(posedge clk_sys) disable iff (reset) // see (R4)
		$rose(pins_reg.writeStrobeN) |-> lowCnt_reg >= TMR_W'(cur_reg.keepOeLow ?
			WZ_CYC + STROBE_OE_CYC : PULSE_CYC))
		else $error("write strobe too short");

	select_lead_a: assert property (@(posedge clk_sys) disable iff (reset) // see (R6)
		$fell(pins_reg.selectN) |-> pins_reg.writeStrobeN [*1])
		else $error("strobe fell before arbitration settled");

	write_hold_a: assert property (@(posedge clk_sys) disable iff (reset) // see (R10)
		$rose(pins_reg.writeStrobeN) && blocked_reg |-> relCnt_reg >= TMR_W'(WR_HOLD_CYC))
		else $error("strobe released too soon after contention");

	end_order_a: assert property (@(posedge clk_sys) disable iff (reset) // see (R5)
		$rose(pins_reg.writeStrobeN) |-> !pins_reg.selectN ##1 pins_reg.selectN)
		else $error("select did not outlast strobe by one cycle");

	data_drive_a: assert property (@(posedge clk_sys) disable iff (reset) // see (R3)
		pins_reg.dataOutEn |-> !pins_reg.writeStrobeN && !pins_reg.selectN)
		else $error("data driven outside write overlap");
endmodule : dpwa_port_ctrl
